// file: common/sac_pkg.sv
package sac_pkg;

  // Register offsets on the plain register port.
  localparam logic [2:0] SAC_OFF_CTRL_A  = 3'h0;
  localparam logic [2:0] SAC_OFF_CTRL_B  = 3'h1;
  localparam logic [2:0] SAC_OFF_INSEL   = 3'h2;
  localparam logic [2:0] SAC_OFF_RES_LO  = 3'h3;
  localparam logic [2:0] SAC_OFF_RES_HI  = 3'h4;
  localparam logic [2:0] SAC_OFF_PWR     = 3'h5;

  // Field positions of converter_control_status_a.
  localparam int SAC_A_EN      = 7;
  localparam int SAC_A_START   = 6;
  localparam int SAC_A_AUTO    = 5;
  localparam int SAC_A_DONE    = 4;
  localparam int SAC_A_IRQEN   = 3;
  localparam int SAC_A_PRESC   = 0;
  // Field positions of input_select_register.
  localparam int SAC_I_REF     = 6;
  localparam int SAC_I_LEFT    = 5;
  localparam int SAC_I_CHAN    = 0;
  // Field positions of converter_control_status_b and power register.
  localparam int SAC_B_TSEL    = 0;
  localparam int SAC_P_PR      = 0;

  // Reset values.
  localparam logic [7:0] SAC_RST_CTRL_A = 8'h00;
  localparam logic [7:0] SAC_RST_CTRL_B = 8'h00;
  localparam logic [7:0] SAC_RST_INSEL  = 8'h00;
  localparam logic [9:0] SAC_RST_RESULT = 10'h000;
  localparam logic       SAC_RST_PR     = 1'b0;

  // Conversion timing in ADC clock cycles, as printed.
  localparam int  SAC_CONV_NORM_CYC  = 13;
  localparam int  SAC_CONV_FIRST_CYC = 25;
  localparam real SAC_SAMP_NORM_CYC  = 1.5;
  localparam real SAC_SAMP_FIRST_CYC = 13.5;
  localparam int  SAC_SAMP_AUTO_CYC  = 2;
  localparam real SAC_CONV_AUTO_CYC  = 13.5;

  // The same figures in ADC half cycles, the unit the sequencer counts in.
  localparam logic [5:0] SAC_END_NORM  = 6'(2 * SAC_CONV_NORM_CYC);
  localparam logic [5:0] SAC_END_FIRST = 6'(2 * SAC_CONV_FIRST_CYC);
  localparam logic [5:0] SAC_END_AUTO  = 6'(int'(2.0 * SAC_CONV_AUTO_CYC));
  localparam logic [5:0] SAC_SMP_NORM  = 6'(int'(2.0 * SAC_SAMP_NORM_CYC));
  localparam logic [5:0] SAC_SMP_FIRST = 6'(int'(2.0 * SAC_SAMP_FIRST_CYC));
  localparam logic [5:0] SAC_SMP_AUTO  = 6'(2 * SAC_SAMP_AUTO_CYC);

  typedef enum logic [1:0] {
    SAC_KIND_NORM,
    SAC_KIND_FIRST,
    SAC_KIND_AUTO
  } sac_kind_t;

endpackage

// file: rtl/sac_conv_ctrl.sv
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sac_conv_ctrl
  import sac_pkg::*;
#(
  parameter int TRIG_W = 8
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [2:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              global_irq_enable,
  input  wire logic [TRIG_W-1:0] trig_in,
  input  wire logic [9:0]        core_result,
  output logic                   irq,
  output logic                   core_enable,
  output logic      [3:0]        core_chan,
  output logic      [1:0]        core_ref,
  output logic                   core_sample,
  output logic                   core_busy
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       en;
    logic       start;
    logic       busy;
    logic       first;
    sac_kind_t  kind;
    logic       done;
    logic       irq_en;
    logic [2:0] presc;
    logic       auto_en;
    logic [2:0] tsel;
    logic [1:0] ref_sel;
    logic       left;
    logic [3:0] chan;
    logic [1:0] ref_act;
    logic [3:0] chan_act;
    logic [9:0] res;
    logic       lock;
    logic       pr;
    logic [6:0] pcnt;
    logic [5:0] hc;
    logic       trig_prev;
    logic       sample;
    logic [7:0] rdata;
  } sac_state_t;

  sac_state_t st;
  sac_state_t next_st;

  // Division ratio of the prescaler; settings 0 and 1 both divide by two.
  function automatic logic [7:0] sac_div(input logic [2:0] sel);
    sac_div = (sel == 3'h0) ? 8'h02 : 8'(8'h01 << sel);
  endfunction

  function automatic logic [5:0] sac_end(input sac_kind_t k);
    case (k)
      SAC_KIND_FIRST: sac_end = SAC_END_FIRST;
      SAC_KIND_AUTO:  sac_end = SAC_END_AUTO;
      default:        sac_end = SAC_END_NORM;
    endcase
  endfunction

  function automatic logic [5:0] sac_smp(input sac_kind_t k);
    case (k)
      SAC_KIND_FIRST: sac_smp = SAC_SMP_FIRST;
      SAC_KIND_AUTO:  sac_smp = SAC_SMP_AUTO;
      default:        sac_smp = SAC_SMP_NORM;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] div;
  logic       adc_rise;
  logic       adc_fall;
  logic [5:0] hc_inc;
  logic       complete;
  logic       free_run;
  logic       trig_lvl;
  logic       trig_edge;
  logic       auto_start;
  logic       sw_start;
  logic       track;

  always_comb
  begin
    div       = sac_div(st.presc);
    adc_rise  = st.en && (st.pcnt == 7'(div - 8'h01));
    adc_fall  = st.en && (st.pcnt == 7'((div >> 1) - 8'h01));
    hc_inc    = st.hc + 6'h01;
    complete  = st.busy && (adc_rise || adc_fall) && (hc_inc == sac_end(st.kind));
    free_run  = st.auto_en && (st.tsel == 3'h0);
    trig_lvl  = (st.tsel == 3'h0) ? st.done : trig_in[st.tsel];
    trig_edge = trig_lvl && !st.trig_prev;
    // Only edges seen while idle count, so a level still high at completion
    // has no fresh edge and cannot restart the converter.
    auto_start = st.en && st.auto_en && !free_run && !st.busy
                 && trig_edge;
    sw_start   = st.en && st.start && !st.busy && adc_rise && !auto_start;
    track      = !st.busy || (hc_inc >= sac_end(st.kind) - 6'h02);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st           = st;
    next_st.sample    = 1'b0;
    next_st.trig_prev = trig_lvl;

    // Prescaler.
    if (!st.en || auto_start)
      next_st.pcnt = 7'h00;
    else if (adc_rise)
      next_st.pcnt = 7'h00;
    else
      next_st.pcnt = st.pcnt + 7'h01;

    // Selection reaches the core only at safe points.
    if (st.en && track)
    begin
      next_st.chan_act = st.chan;
      next_st.ref_act  = st.ref_sel;
    end

    // Conversion sequencer. It counts ADC half cycles, so the half-cycle
    // sample instants of the normal and first conversions fall on an edge
    // of their own and need no second counter.
    if (st.busy && (adc_rise || adc_fall))
    begin
      next_st.hc = hc_inc;
      if (hc_inc == sac_smp(st.kind))
        next_st.sample = 1'b1;
    end
    if (complete)
    begin
      next_st.busy = 1'b0;
      next_st.done = 1'b1;
      if (!st.lock)
        next_st.res = core_result;
      if (free_run)
      begin
        next_st.busy = 1'b1;
        next_st.kind = SAC_KIND_NORM;
        next_st.hc   = 6'h00;
      end
      else
        next_st.start = 1'b0;
    end
    if (auto_start || sw_start)
    begin
      next_st.busy  = 1'b1;
      next_st.start = 1'b1;
      next_st.hc    = 6'h00;
      next_st.first = 1'b0;
      next_st.kind  = st.first ? SAC_KIND_FIRST
                      : (auto_start ? SAC_KIND_AUTO : SAC_KIND_NORM);
    end

    // Register writes.
    if (reg_wr)
    begin
      case (reg_addr)
        SAC_OFF_CTRL_A:
        begin
          next_st.en     = reg_wdata[SAC_A_EN] && !st.pr;
          next_st.auto_en = reg_wdata[SAC_A_AUTO];
          next_st.irq_en = reg_wdata[SAC_A_IRQEN];
          next_st.presc  = reg_wdata[SAC_A_PRESC +: 3];
          if (reg_wdata[SAC_A_START] && !st.pr && reg_wdata[SAC_A_EN])
            next_st.start = 1'b1;
          if (reg_wdata[SAC_A_DONE] && !complete)
            next_st.done = 1'b0;
          if (!st.en && reg_wdata[SAC_A_EN])
            next_st.first = 1'b1;
        end
        SAC_OFF_CTRL_B:
          next_st.tsel = reg_wdata[SAC_B_TSEL +: 3];
        SAC_OFF_INSEL:
        begin
          next_st.ref_sel = reg_wdata[SAC_I_REF +: 2];
          next_st.left    = reg_wdata[SAC_I_LEFT];
          next_st.chan    = reg_wdata[SAC_I_CHAN +: 4];
        end
        SAC_OFF_PWR:
          next_st.pr = reg_wdata[SAC_P_PR];
        default:
          next_st.pr = st.pr;
      endcase
    end

    // Disabling aborts everything; the prescaler is already held above.
    if (!next_st.en || next_st.pr)
    begin
      next_st.en    = 1'b0;
      next_st.busy  = 1'b0;
      next_st.start = 1'b0;
    end

    // Register reads; read data stand in the following cycle only.
    // Reading the low byte locks the result pair so that software sees both
    // halves of one conversion unless one completes in the cycle of that read,
    // at the cost of losing any result that completes before the high byte is read.
    next_st.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        SAC_OFF_CTRL_A:
          next_st.rdata = {st.en, st.start || st.busy, st.auto_en, st.done,
                           st.irq_en, st.presc};
        SAC_OFF_CTRL_B:
          next_st.rdata = {5'h00, st.tsel};
        SAC_OFF_INSEL:
          next_st.rdata = {st.ref_sel, st.left, 1'b0, st.chan};
        SAC_OFF_RES_LO:
        begin
          next_st.rdata = st.left ? {st.res[1:0], 6'h00}
                                  : st.res[7:0];
          next_st.lock  = 1'b1;
        end
        SAC_OFF_RES_HI:
        begin
          next_st.rdata = st.left ? st.res[9:2]
                                  : {6'h00, st.res[9:8]};
          next_st.lock  = 1'b0;
        end
        SAC_OFF_PWR:
          next_st.rdata = {7'h00, st.pr};
        default:
          next_st.rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st         <= '0;
      st.en      <= SAC_RST_CTRL_A[SAC_A_EN];
      st.presc   <= SAC_RST_CTRL_A[SAC_A_PRESC +: 3];
      st.tsel    <= SAC_RST_CTRL_B[SAC_B_TSEL +: 3];
      st.chan    <= SAC_RST_INSEL[SAC_I_CHAN +: 4];
      st.res     <= SAC_RST_RESULT;
      st.pr      <= SAC_RST_PR;
      st.kind    <= SAC_KIND_NORM;
    end
    else
      st <= next_st;
  end

  assign reg_rdata   = st.rdata;
  assign irq         = st.done && st.irq_en && global_irq_enable;
  assign core_enable = st.en;
  assign core_chan   = st.chan_act;
  assign core_ref    = st.ref_act;
  assign core_sample = st.sample;
  assign core_busy   = st.busy;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pr_blocks_en_a: assert property (st.pr |-> !st.en)
    else $error("converter enabled under power reduction");
  start_clear_a: assert property (complete && !free_run && !auto_start
    && !(reg_wr && reg_addr == SAC_OFF_CTRL_A) |=> !st.start)
    else $error("start bit not cleared at completion");
  lock_hold_a: assert property (st.lock && !(reg_rd && reg_addr == SAC_OFF_RES_HI)
    |=> $stable(st.res))
    else $error("result changed while locked");
  done_set_a: assert property (complete |=> st.done)
    else $error("done flag not set at completion");
  busy_reads_a: assert property (st.busy && reg_rd && reg_addr == SAC_OFF_CTRL_A
    |=> reg_rdata[SAC_A_START])
    else $error("start bit reads zero while busy");
  chan_freeze_a: assert property (st.busy && !track |=> $stable(core_chan))
    else $error("channel changed mid conversion");
  presc_held_a: assert property (!st.en |=> st.pcnt == 7'h00 || st.en)
    else $error("prescaler counts while disabled");
  free_run_a: assert property (complete && free_run && st.en
    && !(reg_wr && reg_addr != SAC_OFF_CTRL_B) |=> st.busy && st.start)
    else $error("free running did not restart");
  sample_busy_a: assert property (core_sample |-> $past(st.busy))
    else $error("sample outside a conversion");

  //////////////////////////////////////////////////////////////////////////////
  // Start timing, prescaler and power checks.
  sw_start_edge_a: assert property ($rose(st.busy)
    && !$past(auto_start) |-> $past(adc_rise))
    else $error("software start off the ADC clock edge");
  auto_presc_a: assert property (auto_start && !reg_wr
    |=> st.busy && st.pcnt == 7'h00)
    else $error("auto trigger did not reset prescaler and start");
  presc_enable_a: assert property ($rose(st.en) |-> st.pcnt == 7'h00)
    else $error("prescaler not counting from zero at enable");
  pr_blocks_busy_a: assert property (st.pr |-> !st.busy && !st.start)
    else $error("conversion active under power reduction");
  busy_start_a: assert property (st.busy |-> st.start)
    else $error("start bit low during a conversion");

  // Selection, sampling and result checks.
  off_chan_a: assert property (!st.en |=> $stable(core_chan))
    else $error("channel reached the core while disabled");
  sample_place_a: assert property (core_sample
    |-> st.hc == sac_smp(st.kind))
    else $error("sample pulse at the wrong half cycle");
  result_write_a: assert property (complete && !st.lock
    |=> st.res == $past(core_result))
    else $error("result not written at completion");
  unlock_a: assert property (reg_rd && reg_addr == SAC_OFF_RES_HI
    |=> !st.lock)
    else $error("high byte read did not lift the lock");

  // Readout layout checks; the read data stand one cycle after the strobe.
  left_high_a: assert property (reg_rd && reg_addr == SAC_OFF_RES_HI
    && st.left |=> reg_rdata == $past(st.res[9:2]))
    else $error("left adjusted high byte wrong");
  right_low_a: assert property (reg_rd && reg_addr == SAC_OFF_RES_LO
    && !st.left |=> reg_rdata == $past(st.res[7:0]))
    else $error("right adjusted low byte wrong");

  first_conv_c: cover property (st.kind == SAC_KIND_FIRST && complete);
  auto_conv_c: cover property (auto_start ##[1:300] complete);
  lost_result_c: cover property (st.lock && complete);
  free_run_c: cover property (complete && free_run);
  lock_release_c: cover property (st.lock && reg_rd
    && reg_addr == SAC_OFF_RES_HI);

endmodule

`default_nettype wire

// file: verif/sac_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module sac_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       core_enable,
  input  wire logic [3:0] core_chan,
  input  wire logic [1:0] core_ref,
  input  wire logic       core_sample,
  input  wire logic       core_busy,
  output logic      [9:0] core_result
);
  logic [9:0] held;

  // The code names the channel and reference seen at the sample instant.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      held <= 10'h000;
    else if (core_sample && core_enable)
      held <= {core_ref, core_chan, 4'h9};
  end

  // Between conversions the lines are not held, so show a wrong value.
  assign core_result = core_busy ? held : ~held;
endmodule

`default_nettype wire

// file: verif/test_sac_conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("Error t=%0t got %h exp %h", $time, g, e); end end

module test_sac_conv_ctrl import sac_pkg::*;;
  logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       gie = 1'b0, rd_d = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, rnd = 8'h25, trig_in = 8'h00, ev;
  logic [7:0] reg_rdata;
  logic [9:0] core_result, res_a, res_b;
  logic [3:0] core_chan, ch;
  logic [1:0] core_ref;
  logic       irq, core_enable, core_sample, core_busy;
  logic [7:0] rd_q[$];
  int         len_q[$];
  int         mismatches = 0, checks_done = 0, bcnt = 0, smp_n = 0, smp0, el;

  sac_conv_ctrl #(.TRIG_W(8)) uut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_enable(gie),
    .trig_in(trig_in), .core_result(core_result), .irq(irq),
    .core_enable(core_enable), .core_chan(core_chan), .core_ref(core_ref),
    .core_sample(core_sample), .core_busy(core_busy));
  sac_core_model core (.clk(clk), .rst_n(rst_n), .core_enable(core_enable),
    .core_chan(core_chan), .core_ref(core_ref), .core_sample(core_sample),
    .core_busy(core_busy), .core_result(core_result));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      ev = rd_q.pop_front();
      `CHK(reg_rdata, ev)
    end
    if (!core_busy && bcnt != 0 && len_q.size() != 0)
    begin
      el = len_q.pop_front();
      `CHK(bcnt, el)
    end
    rd_d <= reg_rd;
    smp_n <= smp_n + int'(core_sample);
    bcnt <= core_busy ? bcnt + 1 : 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] bytes(input logic [9:0] r, input logic l);
    return l ? {r, 6'h00} : {6'h00, r};
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic res(input logic [15:0] e);
    rd(SAC_OFF_RES_LO, e[7:0]);
    rd(SAC_OFF_RES_HI, e[15:8]);
  endtask
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 400 && core_busy !== lvl; i++)
      @(posedge clk);
    if (core_busy !== lvl)
      mismatches++;
  endtask
  task automatic start(input logic [7:0] c, input int n);
    len_q.push_back(n);
    wr(SAC_OFF_CTRL_A, c);
    rd(SAC_OFF_CTRL_A, (c & 8'hef) | 8'h40);
    wait_busy(1'b1);
  endtask
  task automatic finish(input logic [7:0] c);
    wait_busy(1'b0);
    rd(SAC_OFF_CTRL_A, (c & 8'haf) | 8'h10);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #50000;
    mismatches++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    gie <= 1'b1;
    rd(SAC_OFF_CTRL_A, SAC_RST_CTRL_A);
    rd(SAC_OFF_CTRL_B, SAC_RST_CTRL_B);
    rd(SAC_OFF_INSEL, SAC_RST_INSEL);
    res(16'h0000);
    rd(3'h6, 8'h00);
    note("reset");
    wr(SAC_OFF_PWR, 8'h01);
    wr(SAC_OFF_CTRL_A, 8'hc0);
    rd(SAC_OFF_PWR, 8'h01);
    rd(SAC_OFF_CTRL_A, 8'h00);
    `CHK(core_enable, 1'b0)
    wr(SAC_OFF_PWR, 8'h00);
    note("power");
    rnd = lfsr(rnd);
    ch = rnd[3:0];
    res_a = {rnd[7:6], ch, 4'h9};
    wr(SAC_OFF_INSEL, {rnd[7:6], 2'b00, ch});
    `CHK(core_chan, 4'h0)
    // Divide by two keeps the run short; resolution does not matter here.
    wr(SAC_OFF_CTRL_A, 8'h80);
    @(posedge clk);
    `CHK(core_chan, ch)
    start(8'hc0, 2 * SAC_CONV_FIRST_CYC);
    finish(8'hc0);
    res(bytes(res_a, 1'b0));
    note("first");
    wr(SAC_OFF_INSEL, {rnd[7:6], 2'b10, ch});
    start(8'hd0, 2 * SAC_CONV_NORM_CYC);
    rnd = lfsr(rnd);
    wr(SAC_OFF_INSEL, {4'b0010, rnd[3:0]});
    `CHK(core_chan, ch)
    finish(8'hd0);
    `CHK(core_chan, rnd[3:0])
    res(bytes(res_a, 1'b1));
    note("channel");
    res_b = {2'b00, rnd[3:0], 4'h9};
    rd(SAC_OFF_RES_LO, {res_a[1:0], 6'h00});
    start(8'hd2, 4 * SAC_CONV_NORM_CYC);
    finish(8'hd2);
    rd(SAC_OFF_RES_HI, res_a[9:2]);
    start(8'hd0, 2 * SAC_CONV_NORM_CYC);
    finish(8'hd0);
    rd(SAC_OFF_RES_HI, res_b[9:2]);
    note("lock");
    wr(SAC_OFF_CTRL_A, 8'h88);
    `CHK(irq, 1'b1)
    gie <= 1'b0;
    @(posedge clk);
    `CHK(irq, 1'b0)
    gie <= 1'b1;
    wr(SAC_OFF_CTRL_A, 8'h98);
    `CHK(irq, 1'b0)
    note("irq");
    wr(SAC_OFF_CTRL_B, 8'h03);
    wr(SAC_OFF_CTRL_A, 8'ha0);
    smp0 = smp_n;
    len_q.push_back(int'(2.0 * SAC_CONV_AUTO_CYC));
    trig_in <= {rnd[7:4], 1'b1, 3'b000};
    wait_busy(1'b1);
    trig_in <= 8'h00;
    repeat (2) @(posedge clk);
    trig_in <= 8'h08;
    wait_busy(1'b0);
    repeat (10) @(posedge clk);
    `CHK(smp_n - smp0 == 1, 1'b1)
    trig_in <= 8'h00;
    @(posedge clk);
    len_q.push_back(int'(2.0 * SAC_CONV_AUTO_CYC));
    trig_in <= 8'h08;
    wait_busy(1'b1);
    wait_busy(1'b0);
    `CHK(smp_n - smp0 == 2, 1'b1)
    note("auto");
    wr(SAC_OFF_CTRL_B, 8'h00);
    smp0 = smp_n;
    wr(SAC_OFF_CTRL_A, 8'hf0);
    repeat (80) @(posedge clk);
    rd(SAC_OFF_CTRL_A, 8'hf0);
    `CHK(smp_n - smp0 > 2, 1'b1)
    wr(SAC_OFF_CTRL_A, 8'h10);
    rd(SAC_OFF_CTRL_A, 8'h00);
    `CHK(core_enable, 1'b0)
    note("free");
    close_out();
  end
endmodule

`default_nettype wire
